// [dsc_ctrl.sv]
/*
 * Downconverter sync and control register bank, AXI4-Lite slave.
 * Holds oscillator words with immediate or transfer-strobed update,
 * soft reset, SYSREF alignment and downconverter 0 mixer/gain select.
 * Assumes SYSREF is synchronous to core_clk and already enabled upstream.
 */
`timescale 1ns/100ps
`default_nettype none
module dsc_ctrl
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // SYSREF
    input wire logic sysrefIn,
    // Oscillator and datapath controls
    output logic [31:0] tuning_word,
    output logic [31:0] phase_offset_word,
    output logic [31:0] modulus_a_word,
    output logic [31:0] modulus_b_word,
    output logic ncoAlign,
    output logic ddcReset,
    output logic complexMixer,
    output logic gainTimesTwo
);
    typedef struct packed
    {
        logic [11:0] awAddr;
        logic awHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic wHeld;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [7:0] syncCtrl;
        logic [7:0] ddc0Ctrl;
        logic [31:0] shTune;
        logic [31:0] shPhase;
        logic [31:0] shModA;
        logic [31:0] shModB;
        logic [31:0] acTune;
        logic [31:0] acPhase;
        logic [31:0] acModA;
        logic [31:0] acModB;
        logic align;
    } dsc_ctrl_state_t;

    dsc_ctrl_state_t st_q;
    dsc_ctrl_state_t st_d;
    logic alignPulse;
    logic clearSyncEn;
    logic armed;
    logic doWrite;
    logic [7:0] wByte;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        end
        return res;
    endfunction : merge

    dsc_sync_fsm u_sync
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .syncEn(st_q.syncCtrl[dsc_pkg::SYNC_EN_BIT]),
        .nextSync(st_q.syncCtrl[dsc_pkg::NEXT_SYNC_BIT]),
        .sysrefIn(sysrefIn),
        .alignPulse(alignPulse),
        .clearSyncEn(clearSyncEn),
        .armed(armed)
    );

    assign doWrite = st_q.awHeld & st_q.wHeld & ~st_q.bValid;
    assign wByte = st_q.wStrb[0] ? st_q.wData[7:0] : 8'h00;

    always_comb
    begin
        st_d = st_q;
        st_d.align = alignPulse;
        // Write channels taken independently
        // Nothing new is taken while a response waits
        if (s_axi_awvalid && !st_q.awHeld && !st_q.bValid)
        begin
            st_d.awAddr = s_axi_awaddr;
            st_d.awHeld = 1'b1;
        end
        if (s_axi_wvalid && !st_q.wHeld && !st_q.bValid)
        begin
            st_d.wData = s_axi_wdata;
            st_d.wStrb = s_axi_wstrb;
            st_d.wHeld = 1'b1;
        end
        if (st_q.bValid && s_axi_bready)
            st_d.bValid = 1'b0;
        if (doWrite)
        begin
            st_d.awHeld = 1'b0;
            st_d.wHeld = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp = dsc_pkg::RESP_OKAY;
            unique case ({st_q.awAddr[11:2], 2'b00})
                dsc_pkg::SYNC_CTRL_ADDR:
                    if (st_q.wStrb[0])
                        st_d.syncCtrl = st_q.wData[7:0] & dsc_pkg::SYNC_CTRL_MASK;
                dsc_pkg::DDC0_CTRL_ADDR:
                    if (st_q.wStrb[0])
                        st_d.ddc0Ctrl = st_q.wData[7:0];
                dsc_pkg::TUNE_ADDR:
                    st_d.shTune = merge(st_q.shTune, st_q.wData, st_q.wStrb);
                dsc_pkg::PHASE_ADDR:
                    st_d.shPhase = merge(st_q.shPhase, st_q.wData, st_q.wStrb);
                dsc_pkg::MODA_ADDR:
                    st_d.shModA = merge(st_q.shModA, st_q.wData, st_q.wStrb);
                dsc_pkg::MODB_ADDR:
                    st_d.shModB = merge(st_q.shModB, st_q.wData, st_q.wStrb);
                dsc_pkg::XFER_ADDR & 12'hffc:
                    ;
                dsc_pkg::STATUS_ADDR:
                    st_d.bResp = dsc_pkg::RESP_SLVERR;
                default:
                    st_d.bResp = dsc_pkg::RESP_SLVERR;
            endcase
        end
        // Words follow the shadow at once in immediate mode
        if (!st_d.syncCtrl[dsc_pkg::UPD_MODE_BIT])
        begin
            st_d.acTune = st_d.shTune;
            st_d.acPhase = st_d.shPhase;
            st_d.acModA = st_d.shModA;
            st_d.acModB = st_d.shModB;
        end
        else if (doWrite && {st_q.awAddr[11:2], 2'b00} == dsc_pkg::XFER_ADDR && wByte[dsc_pkg::XFER_BIT])
        begin
            // Transfer bit self-clears, so it has no storage
            st_d.acTune = st_q.shTune;
            st_d.acPhase = st_q.shPhase;
            st_d.acModA = st_q.shModA;
            st_d.acModB = st_q.shModB;
        end
        // Hardware clear of the enable; a software write of 1 in the same cycle as the clear always loses
        if (clearSyncEn)
            st_d.syncCtrl[dsc_pkg::SYNC_EN_BIT] = 1'b0;
        // Read channel
        if (st_q.rValid && s_axi_rready)
            st_d.rValid = 1'b0;
        if (s_axi_arvalid && !st_q.rValid)
        begin
            st_d.rValid = 1'b1;
            st_d.rResp = dsc_pkg::RESP_OKAY;
            unique case ({s_axi_araddr[11:2], 2'b00})
                dsc_pkg::SYNC_CTRL_ADDR:
                    st_d.rData = {24'h000000, st_q.syncCtrl & dsc_pkg::SYNC_CTRL_MASK};
                dsc_pkg::DDC0_CTRL_ADDR:
                    st_d.rData = {24'h000000, st_q.ddc0Ctrl};
                dsc_pkg::TUNE_ADDR:
                    st_d.rData = st_q.shTune;
                dsc_pkg::PHASE_ADDR:
                    st_d.rData = st_q.shPhase;
                dsc_pkg::MODA_ADDR:
                    st_d.rData = st_q.shModA;
                dsc_pkg::MODB_ADDR:
                    st_d.rData = st_q.shModB;
                dsc_pkg::XFER_ADDR & 12'hffc:
                    st_d.rData = 32'h00000000;
                dsc_pkg::STATUS_ADDR:
                    st_d.rData = {30'h0, armed, st_q.syncCtrl[dsc_pkg::SYNC_EN_BIT]};
                default:
                begin
                    st_d.rData = 32'h00000000;
                    st_d.rResp = dsc_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
            st_q.syncCtrl <= dsc_pkg::SYNC_CTRL_RST;
            st_q.ddc0Ctrl <= dsc_pkg::DDC0_CTRL_RST;
        end
        else
            st_q <= st_d;
    end

    assign s_axi_awready = ~st_q.awHeld & ~st_q.bValid;
    assign s_axi_wready = ~st_q.wHeld & ~st_q.bValid;
    assign s_axi_bvalid = st_q.bValid;
    assign s_axi_bresp = st_q.bResp;
    assign s_axi_arready = ~st_q.rValid;
    assign s_axi_rvalid = st_q.rValid;
    assign s_axi_rdata = st_q.rData;
    assign s_axi_rresp = st_q.rResp;

    assign tuning_word = st_q.acTune;
    assign phase_offset_word = st_q.acPhase;
    assign modulus_a_word = st_q.acModA;
    assign modulus_b_word = st_q.acModB;
    assign ncoAlign = st_q.align;
    assign ddcReset = st_q.syncCtrl[dsc_pkg::SOFT_RST_BIT];
    assign complexMixer = st_q.ddc0Ctrl[dsc_pkg::MIX_SEL_BIT];
    assign gainTimesTwo = st_q.ddc0Ctrl[dsc_pkg::GAIN_SEL_BIT];
endmodule : dsc_ctrl
`default_nettype wire

// [dsc_ctrl_props.sv]
/*
 * Port-level checker for the downconverter sync and control bank.
 * Assumes binding to dsc_ctrl; sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module dsc_ctrl_props
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sync and datapath
    input wire logic sysrefIn,
    input wire logic ncoAlign,
    input wire logic ddcReset,
    input wire logic complexMixer,
    input wire logic gainTimesTwo,
    input wire logic [31:0] tuning_word,
    input wire logic [31:0] phase_offset_word,
    input wire logic [31:0] modulus_a_word,
    input wire logic [31:0] modulus_b_word
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    AST_ALIGN_CAUSE: assert property (ncoAlign |-> $past(sysrefIn, 2) && !$past(sysrefIn, 3))
        else $error("Alignment without a SYSREF rising edge");
    AST_ALIGN_PULSE: assert property (ncoAlign |=> !ncoAlign)
        else $error("Alignment pulse longer than one cycle");
    AST_WORD_CAUSE: assert property (
        !$stable({tuning_word, phase_offset_word, modulus_a_word, modulus_b_word}) |-> $rose(s_axi_bvalid))
        else $error("Oscillator word changed without a write");
    AST_RST_CAUSE: assert property ($changed(ddcReset) |-> $rose(s_axi_bvalid))
        else $error("Soft reset changed without a write");
    AST_MIX_CAUSE: assert property ($changed({complexMixer, gainTimesTwo}) |-> $rose(s_axi_bvalid))
        else $error("Mixer or gain changed without a write");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before acceptance");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped before acceptance");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address accepted while data pending");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write accepted while response pending");
endmodule : dsc_ctrl_props
bind dsc_ctrl dsc_ctrl_props u_props (.*);
`default_nettype wire

// [dsc_pkg.sv]
/*
 * Shared constants for the downconverter sync and control block:
 * register offsets, field positions, reset values and the sync states.
 * Assumes a 32-bit AXI4-Lite register bus and one core clock.
 */
package dsc_pkg;
    // Register indices; one 32-bit word each, so the byte address is four times the index
    localparam logic [11:0] SYNC_CTRL_IDX = 12'h300;
    localparam logic [11:0] DDC0_CTRL_IDX = 12'h310;
    localparam logic [11:0] XFER_IDX = 12'h00f;
    localparam logic [11:0] TUNE_IDX = 12'h320;
    localparam logic [11:0] PHASE_IDX = 12'h321;
    localparam logic [11:0] MODA_IDX = 12'h322;
    localparam logic [11:0] MODB_IDX = 12'h323;
    localparam logic [11:0] STATUS_IDX = 12'h330;
    // Register byte addresses
    localparam logic [11:0] SYNC_CTRL_ADDR = {SYNC_CTRL_IDX[9:0], 2'b00};
    localparam logic [11:0] DDC0_CTRL_ADDR = {DDC0_CTRL_IDX[9:0], 2'b00};
    localparam logic [11:0] XFER_ADDR = {XFER_IDX[9:0], 2'b00};
    localparam logic [11:0] TUNE_ADDR = {TUNE_IDX[9:0], 2'b00};
    localparam logic [11:0] PHASE_ADDR = {PHASE_IDX[9:0], 2'b00};
    localparam logic [11:0] MODA_ADDR = {MODA_IDX[9:0], 2'b00};
    localparam logic [11:0] MODB_ADDR = {MODB_IDX[9:0], 2'b00};
    localparam logic [11:0] STATUS_ADDR = {STATUS_IDX[9:0], 2'b00};
    // Sync control fields
    localparam int UPD_MODE_BIT = 7;
    localparam int SOFT_RST_BIT = 4;
    localparam int NEXT_SYNC_BIT = 1;
    localparam int SYNC_EN_BIT = 0;
    localparam logic [7:0] SYNC_CTRL_MASK = 8'h93;
    localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
    // Downconverter 0 control fields
    localparam int MIX_SEL_BIT = 7;
    localparam int GAIN_SEL_BIT = 6;
    localparam logic [7:0] DDC0_CTRL_RST = 8'h00;
    // Chip transfer field
    localparam int XFER_BIT = 0;
    localparam logic [31:0] WORD_RST = 32'h00000000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0]
    {
        SYNC_IDLE = 3'b001,
        SYNC_ARMED = 3'b010,
        SYNC_CONT = 3'b100
    } dsc_sync_t;
endpackage : dsc_pkg

// [dsc_sync_fsm.sv]
/*
 * SYSREF edge detection and oscillator alignment sequencing.
 * Assumes SYSREF is already synchronous to core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module dsc_sync_fsm
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Controls
    input wire logic syncEn,
    input wire logic nextSync,
    input wire logic sysrefIn,
    // Results
    output logic alignPulse,
    output logic clearSyncEn,
    output logic armed
);
    typedef struct packed
    {
        dsc_pkg::dsc_sync_t state;
        logic sysrefPrev;
        logic align;
        logic clr;
    } dsc_fsm_state_t;

    dsc_fsm_state_t st_q;
    dsc_fsm_state_t st_d;
    logic edgeSeen;

    assign edgeSeen = sysrefIn & ~st_q.sysrefPrev;

    always_comb
    begin
        st_d = st_q;
        st_d.sysrefPrev = sysrefIn;
        st_d.align = 1'b0;
        st_d.clr = 1'b0;
        unique case (st_q.state)
            dsc_pkg::SYNC_IDLE:
            begin
                // Alignment off while enable is low
                // A clear still on its way must not re-arm for a cycle
                if (syncEn && !st_q.clr)
                    st_d.state = nextSync ? dsc_pkg::SYNC_ARMED : dsc_pkg::SYNC_CONT;
            end
            dsc_pkg::SYNC_ARMED:
            begin
                if (!syncEn)
                    st_d.state = dsc_pkg::SYNC_IDLE;
                else if (edgeSeen)
                begin
                    // Only this edge aligns; later ones are ignored
                    st_d.align = 1'b1;
                    st_d.clr = 1'b1;
                    st_d.state = dsc_pkg::SYNC_IDLE;
                end
            end
            dsc_pkg::SYNC_CONT:
            begin
                if (!syncEn || nextSync)
                    st_d.state = dsc_pkg::SYNC_IDLE;
                else if (edgeSeen)
                    // Relies on SYSREF being a multiple of the oscillator rate
                    st_d.align = 1'b1;
            end
            default:
                st_d.state = dsc_pkg::SYNC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= '{state: dsc_pkg::SYNC_IDLE, sysrefPrev: 1'b0, align: 1'b0, clr: 1'b0};
        else
            st_q <= st_d;
    end

    assign alignPulse = st_q.align;
    assign clearSyncEn = st_q.clr;
    assign armed = (st_q.state == dsc_pkg::SYNC_ARMED);
endmodule : dsc_sync_fsm
`default_nettype wire

// [dsc_sysref_src.sv]
/*
 * SYSREF source model: a burst of two-cycle pulses on request.
 * Assumes period of at least eight cycles, set by the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module dsc_sysref_src
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Burst request
    input wire logic go,
    input wire logic [3:0] pulses,
    input wire logic [7:0] period,
    // SYSREF level, idle low
    output logic sysrefIn
);
    logic [3:0] left;
    logic [7:0] cnt;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            left <= 4'h0;
            cnt <= 8'h00;
            sysrefIn <= 1'b0;
        end
        else if (go)
        begin
            left <= pulses;
            cnt <= 8'h00;
        end
        else if (left != 4'h0)
        begin
            // Period a multiple of four, standing for the oscillator rate
            sysrefIn <= cnt < 8'h02;
            cnt <= (cnt == period - 8'h01) ? 8'h00 : cnt + 8'h01;
            if (cnt == period - 8'h01)
                left <= left - 4'h1;
        end
        else
            sysrefIn <= 1'b0;
    end
endmodule : dsc_sysref_src
`default_nettype wire

// [test_downconverter_sync_and_control.sv]
/*
 * Self-checking bench for the downconverter sync and control bank.
 * Assumes dsc_ctrl, its bound checker and the SYSREF source model.
 */
`timescale 1ns/100ps
`default_nettype none
module test_downconverter_sync_and_control;
    localparam logic [11:0] SYNC = dsc_pkg::SYNC_CTRL_ADDR;
    localparam logic [11:0] DDC0 = dsc_pkg::DDC0_CTRL_ADDR;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sysrefIn;
    logic ncoAlign, ddcReset, complexMixer, gainTimesTwo;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, tuning_word, phase_offset_word, modulus_a_word, modulus_b_word;
    logic sysGo = 1'b0;
    logic [7:0] sysPeriod = 8'h10;
    int fails = 0, cmp_count = 0, alignCnt = 0;
    logic [31:0] outs [4];
    always_comb outs = '{tuning_word, phase_offset_word, modulus_a_word, modulus_b_word};

    dsc_ctrl dut (.*);
    dsc_sysref_src u_src (.core_clk(core_clk), .rst_b(rst_b), .go(sysGo), .pulses(4'h3), .period(sysPeriod),
        .sysrefIn(sysrefIn));

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (ncoAlign === 1'b1)
            alignCnt++;

    function automatic logic [31:0] f_sync(input logic [31:0] d);
        return {24'h000000, d[7:0] & dsc_pkg::SYNC_CTRL_MASK};
    endfunction : f_sync

    // Read response from the register map
    function automatic logic [1:0] f_rresp(input logic [11:0] a);
        logic [11:0] b;
        b = a & 12'hffc;
        if (b inside {SYNC, DDC0, dsc_pkg::XFER_ADDR, dsc_pkg::STATUS_ADDR}
            || (b >= dsc_pkg::TUNE_ADDR && b <= dsc_pkg::MODB_ADDR))
            return dsc_pkg::RESP_OKAY;
        return dsc_pkg::RESP_SLVERR;
    endfunction : f_rresp

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // Response ready raised at a random moment so waiting responses are seen
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (!s_axi_bready)
                s_axi_bready <= 1'($urandom_range(1));
        end
        while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, e});
        repeat (2) @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (!s_axi_rready)
                s_axi_rready <= 1'($urandom_range(1));
        end
        while (!(s_axi_rvalid && s_axi_rready));
        r = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, f_rresp(a)});
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask : rd

    initial
    begin
        #200000;
        fails++;
        end_sim();
    end

    initial
    begin
        logic [31:0] r, d;
        logic [31:0] w [4];
        logic [31:0] ap [4];
        logic [7:0] ctl [3];
        int cnt [3];
        ap = '{default: 32'h0};
        ctl = '{8'h00, 8'h03, 8'h01};
        cnt = '{0, 1, 3};
        void'($urandom(51142));
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(SYNC, r);
        chk(r, {24'h0, dsc_pkg::SYNC_CTRL_RST});
        d = $urandom & 32'hffffff6c;
        wr(SYNC, d, dsc_pkg::RESP_OKAY);
        rd(SYNC, r);
        chk(r, f_sync(d));
        for (int i = 1; i >= 0; i--)
        begin
            wr(SYNC, 32'(i) << 4, dsc_pkg::RESP_OKAY);
            chk({31'h0, ddcReset}, 32'(i));
        end
        for (int i = 0; i < 4; i++)
        begin
            d = ($urandom & 32'h3f) | (32'(i) << 6);
            wr(DDC0, d, dsc_pkg::RESP_OKAY);
            chk({30'h0, complexMixer, gainTimesTwo}, 32'(i));
            rd(DDC0, r);
            chk(r & 32'hc0, d & 32'hc0);
        end
        for (int m = 0; m < 2; m++)
        begin
            wr(SYNC, 32'(m) << 7, dsc_pkg::RESP_OKAY);
            for (int k = 0; k < 4; k++)
            begin
                w[k] = $urandom;
                wr(dsc_pkg::TUNE_ADDR + 12'(4 * k), w[k], dsc_pkg::RESP_OKAY);
                if (m == 0)
                    ap[k] = w[k];
                chk(outs[k], ap[k]);
            end
            wr(dsc_pkg::XFER_ADDR & 12'hffc, 32'(m), dsc_pkg::RESP_OKAY);
            ap = w;
            for (int k = 0; k < 4; k++)
                chk(outs[k], ap[k]);
        end
        wr(12'h3f0, $urandom, dsc_pkg::RESP_SLVERR);
        wr(dsc_pkg::STATUS_ADDR, $urandom, dsc_pkg::RESP_SLVERR);
        rd(12'h3f0, r);
        chk(r, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(SYNC, {24'h0, ctl[i]}, dsc_pkg::RESP_OKAY);
            rd(dsc_pkg::STATUS_ADDR, r);
            chk(r, {30'h0, ctl[i][1] & ctl[i][0], ctl[i][0]});
            sysPeriod <= 8'(4 * (2 + $urandom_range(3)));
            d = 32'(alignCnt);
            sysGo <= 1'b1;
            @(posedge core_clk);
            sysGo <= 1'b0;
            repeat (120) @(posedge core_clk);
            chk(32'(alignCnt) - d, 32'(cnt[i]));
            rd(SYNC, r);
            chk(r, (ctl[i] == 8'h03) ? 32'h2 : {24'h0, ctl[i]});
        end
        end_sim();
    end
endmodule : test_downconverter_sync_and_control
`default_nettype wire
